/* File: act_ain_model.sv */
// Purpose: analog input source that feeds the converter front end
// Assumes: the bench picks the level and range kind before each start
// Notes:   levels are held steady through each whole conversion
`timescale 1ns/1ps
module act_ain_model (
  input  wire logic        hclk,
  input  wire logic [1:0]  kind,
  input  wire logic [9:0]  level,
  output act_pkg::act_ain_t ain
);
  import act_pkg::*;
  // out of range flags; kind 3 raises both so the below case must win
  always_ff @(posedge hclk) begin
    ain <= '{below: kind[0], above: kind[1], code: level};
  end
endmodule : act_ain_model

/* File: act_core.sv */
// Purpose: conversion timing controller with AHB-Lite registers
// Assumes: one clock, hclk; ain from outside this domain
// Notes:   zero wait state slave, always OKAY
`timescale 1ns/1ps
`include "act_params.svh"
module act_core (
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic         hsel,
  input  wire logic [31:0]  haddr,
  input  wire logic [1:0]   htrans,
  input  wire logic         hwrite,
  input  wire logic [2:0]   hsize,
  input  wire logic         hready,
  input  wire logic [31:0]  hwdata,
  output logic [31:0]       hrdata,
  output logic              hreadyout,
  output logic              hresp,
  input  wire act_pkg::act_ain_t ain,
  output logic              sample_on,
  output logic              conv_busy
);
  import act_pkg::*;

  act_state_t st_q, st_d;
  act_ctrl_t  ctrl_q;
  act_ain_t   ain_m_q, ain_s_q;
  logic        wr_q, rd_acc;
  logic [7:0]  addr_q;
  logic [31:0] rdata_q;
  logic [7:0]  div_m1, div_q;
  logic        tick, div_reload;
  logic [6:0]  ts_m1, conv_m1, ph_q, ph_d;
  logic [13:0] cal_q;
  logic        in_cal_q, pend_q, done_q;
  logic [9:0]  res_q;
  logic        start_wr, done_clr, load_end, samp_go;
  logic        sample_q, busy_q;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_q;
  assign sample_on = sample_q;
  assign conv_busy = busy_q;

  // Address phase capture
  assign rd_acc = hsel & htrans[1] & hready;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q   <= 1'b0;
      addr_q <= 8'h00;
    end else begin
      wr_q   <= rd_acc & hwrite;
      addr_q <= haddr[7:0];
    end
  end

  // Read data registered so it stands in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_q <= 32'h0000_0000;
    end else if (rd_acc && !hwrite) begin
      case (haddr[7:0])
        `ACT_OFS_CTRL:   rdata_q <= ctrl_q;
        `ACT_OFS_STATUS: begin
          rdata_q <= 32'h0000_0000;
          rdata_q[`ACT_ST_BUSY] <= busy_q;
          rdata_q[`ACT_ST_CAL]  <= in_cal_q;
          rdata_q[`ACT_ST_DONE] <= done_q;
          rdata_q[`ACT_ST_PEND] <= pend_q;
        end
        `ACT_OFS_RESULT: rdata_q <= {22'h000000, res_q};
        default:         rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  assign div_reload = wr_q && (addr_q == `ACT_OFS_CTRL);
  assign start_wr   = wr_q && (addr_q == `ACT_OFS_START) && hwdata[0];
  assign done_clr   = wr_q && (addr_q == `ACT_OFS_STATUS) && hwdata[`ACT_ST_DONE];

  // Reserved bits stay zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= `ACT_CTRL_RST;
    end else if (div_reload) begin
      ctrl_q         <= hwdata;
      ctrl_q.rsvd_hi <= '0;
      ctrl_q.rsvd_lo <= '0;
    end
  end

  // Analog side comparators are asynchronous to hclk
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ain_m_q <= '0;
      ain_s_q <= '0;
    end else begin
      ain_m_q <= ain;
      ain_s_q <= ain_m_q;
    end
  end

  // R03 improved divider override
  // R01 compatibility divider table
  always_comb begin
    if (ctrl_q.improved_en) begin
      div_m1 = {2'b00, ctrl_q.alt_div};
    end else begin
      case (ctrl_q.basic_clock_divider_select)
        2'b00:   div_m1 = `ACT_DIV_M1_00;
        2'b01:   div_m1 = `ACT_DIV_M1_01;
        2'b10:   div_m1 = `ACT_DIV_M1_10;
        default: div_m1 = `ACT_DIV_M1_11;
      endcase
    end
  end

  // R02 sample time table
  always_comb begin
    case (ctrl_q.sample_time_select)
      2'b00:   ts_m1 = `ACT_TS_M1_00;
      2'b01:   ts_m1 = `ACT_TS_M1_01;
      2'b10:   ts_m1 = `ACT_TS_M1_10;
      default: ts_m1 = `ACT_TS_M1_11;
    endcase
  end

  // R10 bit phase length by resolution
  assign conv_m1 = ctrl_q.res8 ? `ACT_CONV8_M1 : `ACT_CONV10_M1;

  // R09 basic clock derived from hclk only
  // R12 range is software's job, so any code is taken
  assign tick = (div_q >= div_m1);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_q <= 8'h00;
    end else if (div_reload || tick) begin
      div_q <= 8'h00;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end

  assign load_end = (st_q == ST_LOAD) && (ph_q == `ACT_LOAD_M1);
  assign samp_go  = (st_q != ST_SAMP) && (st_d == ST_SAMP);

  // R13 sequencer
  // R05 sample, bits, load in that order
  always_comb begin
    st_d = st_q;
    case (st_q)
      // Start only on a basic clock edge so the sample spans whole periods
      ST_IDLE: begin
        if (pend_q && tick) begin
          st_d = ST_SAMP;
        end
      end
      // R07 conversion pre-empts calibration
      ST_CAL: begin
        if (tick && cal_q >= `ACT_CAL_M1) begin
          st_d = ST_IDLE;
        end else if (pend_q && tick) begin
          st_d = ST_SAMP;
        end
      end
      ST_SAMP: begin
        if (tick && ph_q == ts_m1) begin
          st_d = ST_CONV;
        end
      end
      // R04 post-calibration skipped saves 12 periods
      ST_CONV: begin
        if (tick && ph_q == conv_m1) begin
          st_d = ctrl_q.postcal_en ? ST_POST : ST_LOAD;
        end
      end
      ST_POST: begin
        if (tick && ph_q == `ACT_POST_M1) begin
          st_d = ST_LOAD;
        end
      end
      ST_LOAD: begin
        if (load_end) begin
          st_d = in_cal_q ? ST_CAL : ST_IDLE;
        end
      end
      default: st_d = ST_IDLE;
    endcase
  end

  // R13 phase counter, hclk steps in load
  always_comb begin
    if (st_d != st_q) begin
      ph_d = 7'h00;
    end else if (st_q == ST_LOAD || (tick && st_q != ST_IDLE && st_q != ST_CAL)) begin
      ph_d = ph_q + 7'h01;
    end else begin
      ph_d = ph_q;
    end
  end

  // Calibration starts straight out of reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= ST_CAL;
      ph_q <= 7'h00;
    end else begin
      st_q <= st_d;
      ph_q <= ph_d;
    end
  end

  // R11 calibration length counted in basic periods
  // R07 count holds while a conversion runs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cal_q    <= 14'h0000;
      in_cal_q <= 1'b1;
    end else if (st_q == ST_CAL && tick) begin
      cal_q <= cal_q + 14'h0001;
      if (cal_q >= `ACT_CAL_M1) begin
        in_cal_q <= 1'b0;
      end
    end
  end

  // Start request and done flag: set wins over clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      pend_q <= start_wr | (pend_q & ~samp_go);
      done_q <= load_end | (done_q & ~done_clr);
    end
  end

  // R06 clamp out-of-range inputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      res_q <= 10'h000;
    end else if (load_end) begin
      if (ain_s_q.below) begin
        res_q <= 10'h000;
      end else if (ain_s_q.above) begin
        res_q <= `ACT_RES_ALL1;
      end else if (ctrl_q.res8) begin
        res_q <= ain_s_q.code & `ACT_RES_8MASK;
      end else begin
        res_q <= ain_s_q.code;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sample_q <= 1'b0;
      busy_q   <= 1'b0;
    end else begin
      sample_q <= (st_d == ST_SAMP);
      busy_q   <= (st_d == ST_SAMP) || (st_d == ST_CONV) || (st_d == ST_POST) || (st_d == ST_LOAD);
    end
  end

  // Assertions
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_load6;
    (st_q == ST_LOAD) [*6] ##1 (st_q != ST_LOAD);
  endsequence
  sequence s_gap4;
    (!tick) [*3] ##1 tick;
  endsequence

  chk_div_by_four: assert property ( // R01
    disable iff (!hresetn || div_reload)
    (tick && !ctrl_q.improved_en && ctrl_q.basic_clock_divider_select == 2'b00) |=> s_gap4)
    else $error("basic clock not hclk/4");
  chk_div_improved: assert property ( // R03
    (tick && ctrl_q.improved_en && !div_reload) |=> (div_q == 8'h00))
    else $error("improved divider restart wrong");
  chk_sample_len: assert property ( // R02
    (st_q == ST_SAMP && st_d == ST_CONV) |-> (tick && ph_q == ts_m1))
    else $error("sample phase length wrong");
  chk_postcal_skip: assert property ( // R04
    (st_q == ST_CONV && st_d != ST_CONV) |-> (st_d == (ctrl_q.postcal_en ? ST_POST : ST_LOAD)))
    else $error("post-calibration choice wrong");
  chk_phase_order: assert property ( // R05
    (st_q == ST_SAMP) |=> (st_q == ST_SAMP || st_q == ST_CONV))
    else $error("sample not followed by conversion");
  chk_load_six: assert property ( // R10
    $rose(st_q == ST_LOAD) |-> s_load6)
    else $error("load phase not 6 clocks");
  chk_clamp_low: assert property ( // R06
    (load_end && ain_s_q.below) |=> (res_q == 10'h000))
    else $error("below-ground result not zero");
  chk_clamp_high: assert property ( // R06
    (load_end && !ain_s_q.below && ain_s_q.above) |=> (res_q == `ACT_RES_ALL1))
    else $error("above-reference result not all ones");
  chk_cal_resume: assert property ( // R07
    (load_end && in_cal_q) |=> (st_q == ST_CAL))
    else $error("calibration not resumed");
  chk_cal_min: assert property ( // R11
    $fell(in_cal_q) |-> (cal_q == `ACT_CAL_M1 + 14'h0001))
    else $error("calibration shorter than 484 periods");
  chk_seq_idle: assert property ( // R13
    (load_end && !in_cal_q) |=> (st_q == ST_IDLE) ##1 (st_q == ST_IDLE || st_q == ST_SAMP))
    else $error("sequencer did not return to idle");
endmodule : act_core

/* File: act_core_bench.sv */
// Purpose: self-checking bench of the conversion timing controller
// Assumes: zero wait state bus slave, conversions in compatibility mode only
// Notes:   timing is checked with one divider period of slack at start
`timescale 1ns/1ps
`include "act_params.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin err_total++; \
  $display("Error t=%0t got %h exp %h", $time, (g), (e)); end end
module adc_conversion_timing_bench;
  import act_pkg::*;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        sample_on;
  logic        conv_busy;
  logic [1:0]  kind = 2'h0;
  logic [9:0]  level = 10'h0;
  act_ain_t    ain;
  logic [31:0] rq[$];
  logic [31:0] mq[$];
  logic [31:0] re;
  logic [31:0] rm;
  logic        rd_ph = 1'b0;
  int          sq[$];
  int          bq[$];
  int          dq[$];
  int          sc = 0;
  int          bc = 0;
  int          es;
  int          eb;
  int          ed;
  int          err_total = 0;
  int          checks = 0;
  int          dt[4] = '{4, 2, 16, 8};
  int          tt[4] = '{8, 16, 32, 64};

  always #25 hclk = ~hclk;

  act_core i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .ain(ain), .sample_on(sample_on), .conv_busy(conv_busy));
  act_ain_model i_src (.hclk(hclk), .kind(kind), .level(level), .ain(ain));

  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask : bus

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    rq.push_back(e);
    mq.push_back(m);
    bus(a, 1'b0, 32'h0);
  endtask : rd

  task automatic wait_busy(input logic v);
    int n;
    n = 0;
    while (conv_busy !== v && n < 3000) begin
      @(posedge hclk);
      n++;
    end
    if (n >= 3000) err_total++;
  endtask : wait_busy

  // Read data are judged in the data phase, masked to the fields in play
  always @(posedge hclk) begin
    if (rd_ph && hreadyout === 1'b1) begin
      re = rq.pop_front();
      rm = mq.pop_front();
      `CHK(hrdata & rm, re)
    end
    rd_ph = hsel && htrans[1] && hreadyout && !hwrite;
  end

  // Phase lengths in hclk cycles, judged when busy drops
  always @(posedge hclk) begin
    if (sample_on === 1'b1) sc++;
    if (conv_busy === 1'b1) begin
      bc++;
    end else if (bc > 0) begin
      es = sq.pop_front();
      eb = bq.pop_front();
      ed = dq.pop_front();
      `CHK(sc >= es && sc <= es + ed, 1'b1)
      `CHK(bc >= eb && bc <= eb + ed, 1'b1)
      sc = 0;
      bc = 0;
    end
  end

  task automatic summarize;
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : summarize

  initial begin
    #(50 * 60000);
    err_total++;
    summarize();
  end

  initial begin
    logic [31:0] d;
    logic [1:0]  pc;
    logic [1:0]  r8;
    logic [9:0]  ex;
    int          dv;
    int          ts;
    void'($urandom(32'hFE62D60E));
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    rd(`ACT_OFS_CTRL, `ACT_CTRL_RST, 32'hFFFF_FFFF);
    // conversion asked for during calibration, default control word
    sq.push_back(8 * 4);
    bq.push_back((8 + 40 + 12) * 4 + 6);
    dq.push_back(4);
    bus(`ACT_OFS_START, 1'b1, 32'h1);
    wait_busy(1'b1);
    wait_busy(1'b0);
    rd(`ACT_OFS_STATUS, 32'h6, 32'hF);
    bus(`ACT_OFS_STATUS, 1'b1, 32'h4);
    // 484 basic periods at divide by 4, stretched by that conversion
    repeat (1800) @(posedge hclk);
    rd(`ACT_OFS_STATUS, 32'h2, 32'h2);
    repeat (200) @(posedge hclk);
    rd(`ACT_OFS_STATUS, 32'h0, 32'h2);
    // alt divider kept at 16 or less
    d = $urandom() & 32'hFFCF_FFFF;
    wr_unmapped: bus(8'hF0, 1'b1, d);
    rd(8'hF0, 32'h0, 32'hFFFF_FFFF);
    bus(`ACT_OFS_CTRL, 1'b1, d);
    rd(`ACT_OFS_CTRL, d & 32'h003F_F007, 32'hFFFF_FFFF);
    // every divider code keeps 0.5 to 20 MHz
    for (int i = 0; i < 16; i++) begin
      dv = dt[i / 4];
      ts = tt[i % 4];
      pc = 2'($urandom() % 2);
      r8 = 2'($urandom() % 2);
      d = {16'h0, 2'(i / 4), 2'(i % 4), 12'h0 | {pc[0] ? 12'h1 : 12'h0} | {r8[0] ? 12'h2 : 12'h0}};
      bus(`ACT_OFS_CTRL, 1'b1, d);
      kind <= 2'($urandom() % 4);
      level <= 10'($urandom());
      sq.push_back(ts * dv);
      bq.push_back((ts + (r8[0] ? 32 : 40) + (pc[0] ? 12 : 0)) * dv + 6);
      dq.push_back(dv);
      bus(`ACT_OFS_START, 1'b1, 32'h1);
      wait_busy(1'b1);
      wait_busy(1'b0);
      ex = kind[0] ? 10'h000 : kind[1] ? `ACT_RES_ALL1 : r8[0] ? level & `ACT_RES_8MASK : level;
      rd(`ACT_OFS_RESULT, {22'h0, ex}, 32'h3FF);
      rd(`ACT_OFS_STATUS, 32'h4, 32'hD);
      bus(`ACT_OFS_STATUS, 1'b1, 32'h4);
    end
    repeat (4) @(posedge hclk);
    summarize();
  end
endmodule : adc_conversion_timing_bench

/* File: act_params.svh */
// Purpose: constants of the converter timing controller
// Assumes: hclk at 20 MHz, system clock equals CPU clock
// Notes:   register offsets are byte addresses on AHB-Lite
// Functional notes
// R01 - In compatibility mode control bits 15..14 divide the system clock by 4, 2, 16 or 8 for codes 00..11.
// R02 - In compatibility mode control bits 13..12 give a sample time of 8, 16, 32 or 64 basic clock periods.
// R03 - The fixed encodings hold only in compatibility mode; an improved divider may be selected instead.
// R04 - With post-calibration off a conversion ends 12 basic clock periods sooner.
// R05 - A conversion runs sample, result determination, then a result load on the system clock.
// R06 - Inputs below ground read as all zeros and inputs above the reference read as all ones.
// R07 - After reset a calibration runs; conversions asked for meanwhile are done and stretch it.
// R08 - Software keeps the chosen basic clock within its allowed frequency range.
// R09 - The converter runs from the system clock, which equals the CPU clock.
// R10 - A 10-bit conversion takes 52 or 40 basic periods, 8-bit 44 or 32, plus sample time and 6 system clocks.
// R11 - The reset calibration lasts between 484 and 11,696 basic clock periods.
// R12 - The basic clock must stay between 0.5 MHz and 20 MHz.
// R13 - A cycle counter on the basic clock walks sample, bits, post-calibration and load, then idles.
`ifndef ACT_PARAMS_SVH
`define ACT_PARAMS_SVH
`define ACT_OFS_CTRL    8'h00
`define ACT_OFS_START   8'h04
`define ACT_OFS_STATUS  8'h08
`define ACT_OFS_RESULT  8'h0C
`define ACT_DIV_M1_00   8'h03
`define ACT_DIV_M1_01   8'h01
`define ACT_DIV_M1_10   8'h0F
`define ACT_DIV_M1_11   8'h07
`define ACT_TS_M1_00    7'h07
`define ACT_TS_M1_01    7'h0F
`define ACT_TS_M1_10    7'h1F
`define ACT_TS_M1_11    7'h3F
`define ACT_CONV10_M1   7'h27
`define ACT_CONV8_M1    7'h1F
`define ACT_POST_M1     7'h0B
`define ACT_LOAD_M1     7'h05
`define ACT_CAL_M1      14'h01E3
`define ACT_RES_ALL1    10'h3FF
`define ACT_RES_8MASK   10'h3FC
`define ACT_CTRL_RST    32'h0000_0001
`define ACT_ST_BUSY     0
`define ACT_ST_CAL      1
`define ACT_ST_DONE     2
`define ACT_ST_PEND     3
`endif

/* File: act_pkg.sv */
// Purpose: types of the converter timing controller
// Assumes: act_params.svh holds the numbers
// Notes:   control word layout is a packed struct
package act_pkg;
  typedef enum logic [2:0] {
    ST_IDLE, ST_CAL, ST_SAMP, ST_CONV, ST_POST, ST_LOAD
  } act_state_t;

  // Converter control word, bit 31 down to 0
  typedef struct packed {
    logic [9:0] rsvd_hi;
    logic [5:0] alt_div;
    logic [1:0] basic_clock_divider_select;
    logic [1:0] sample_time_select;
    logic [8:0] rsvd_lo;
    logic       improved_en;
    logic       res8;
    logic       postcal_en;
  } act_ctrl_t;

  // Front-end comparator view of the selected input
  typedef struct packed {
    logic       below;
    logic       above;
    logic [9:0] code;
  } act_ain_t;
endpackage : act_pkg
